// [hw/radio_channel_config.sv]
// Configuration command handler for a sub-GHz radio: special commands,
// parameter writes and reads, channel masks and identifier filtering.
// Assumes a command source on sys_clk that waits for cmd_ready.
`timescale 1ns/1ps
`include "radio_cfg_params.svh"

// Functional notes
// - Soft reset leaves command mode
// - Apply puts pending settings into effect
// - Save copies parameters to non-volatile storage
// - Restore sets factory defaults in pending and active parameters, not in storage
// - Available-frequency bitfield is read-only, per region
// - Bit zero is the lowest frequency channel
// - Spacing 250 kHz; rate 2: 500/450
// - Mask query returns operating mask
// - Rate 2 uses fixed region mask
// - Channel active only if mask and available
// - Mask read-only in two regions
// - Minimum channel count read-only, rate dependent except in US and FR
// - Widest region default mask: alternate channels
// - Preamble id 0 to 9, default 0
// - Preamble id checked before network id
// - Rate select 0..2, default 2
// - Network id up to 0x7FFF, mismatches rejected
module radio_channel_config #(
  parameter int unsigned RESET_DELAY_CYC = `SOFT_RST_DELAY_MS * `SYS_CLK_KHZ,
  parameter int unsigned NV_WRITE_CYC = `NV_WRITE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Power-up storage erase and region strap
  input wire logic nv_erase,
  input wire logic [2:0] region_sel,
  // Command mode
  input wire logic cmd_mode_enter,
  input wire logic cmd_mode_exit,
  output logic in_cmd_mode_r,
  // Command request
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [2:0] cmd_param,
  input wire logic [63:0] cmd_wdata,
  output logic cmd_ready_r,
  // Command response
  output logic rsp_valid_r,
  output logic rsp_ok_r,
  output logic rsp_err_r,
  output logic [63:0] rsp_data_r,
  // Device reset request
  output logic dev_reset_r,
  // Operating channel state
  output logic [1:0] rf_rate_select_r,
  output logic [`CHMASK_W-1:0] available_freq_bits_r,
  output logic [`CHMASK_W-1:0] channel_enable_mask_r,
  output logic [`CHMASK_W-1:0] active_channels_r,
  output logic [7:0] min_channel_count_r,
  output logic [9:0] chan_spacing_khz_r,
  // Receive filtering
  input wire logic rx_hdr_valid,
  input wire logic [3:0] rx_preamble_id,
  input wire logic [14:0] rx_net_id,
  output logic rx_accept_r,
  output logic rx_drop_preamble_r,
  output logic rx_drop_net_r
);

  localparam int NVW = NV_WRITE_CYC;

  // The delay counter is 24 bits wide and the save check needs a bounded window
  if (RESET_DELAY_CYC < 2 || RESET_DELAY_CYC >= 32'h0100_0000) begin : g_bad_delay
    $error("RESET_DELAY_CYC out of range");
  end
  if (NV_WRITE_CYC < 1 || NV_WRITE_CYC > 500) begin : g_bad_nv
    $error("NV_WRITE_CYC out of range");
  end

  typedef struct packed {
    radio_cfg_pkg::fsm_t fsm;
    logic [23:0] cnt;
    radio_cfg_pkg::region_t region;
    radio_cfg_pkg::param_set_t pend;
    radio_cfg_pkg::param_set_t act;
    radio_cfg_pkg::param_set_t nv;
    logic nv_valid;
    logic in_cmd;
    logic ready;
    logic rsp_valid;
    logic rsp_ok;
    logic rsp_err;
    logic [63:0] rsp_data;
    logic dev_reset;
    logic [`CHMASK_W-1:0] af;
    logic [`CHMASK_W-1:0] op_mask;
    logic [`CHMASK_W-1:0] active;
    logic [7:0] minch;
    logic [9:0] spacing;
  } state_t;

  state_t q, d;

  // ==========================================================
  // Region tables
  function automatic logic [`CHMASK_W-1:0] af_bits(radio_cfg_pkg::region_t r,
                                                  logic [1:0] rate);
    logic hi;
    hi = (rate == `RATE_MAX);
    unique case (r)
      radio_cfg_pkg::REG_US: af_bits = hi ? `AF_US_HI : `AF_US_LO;
      radio_cfg_pkg::REG_AU: af_bits = hi ? `AF_AU_HI : `AF_AU_LO;
      radio_cfg_pkg::REG_NZ: af_bits = hi ? `AF_NZ_HI : `AF_NZ_LO;
      radio_cfg_pkg::REG_BR: af_bits = hi ? `AF_BR_HI : `AF_BR_LO;
      radio_cfg_pkg::REG_FR: af_bits = hi ? `AF_FR_HI : `AF_FR_LO;
      default: af_bits = '0;
    endcase
  endfunction

  function automatic logic [`CHMASK_W-1:0] cm_table(radio_cfg_pkg::region_t r,
                                                   logic hi);
    unique case (r)
      radio_cfg_pkg::REG_US: cm_table = hi ? `CM_US_HI : `CM_US_LO;
      radio_cfg_pkg::REG_AU: cm_table = hi ? `CM_AU_HI : `CM_AU_LO;
      radio_cfg_pkg::REG_NZ: cm_table = hi ? `CM_NZ_HI : `CM_NZ_LO;
      radio_cfg_pkg::REG_BR: cm_table = hi ? `CM_BR_HI : `CM_BR_LO;
      radio_cfg_pkg::REG_FR: cm_table = hi ? `CM_FR_HI : `CM_FR_LO;
      default: cm_table = '0;
    endcase
  endfunction

  function automatic logic [7:0] min_count(radio_cfg_pkg::region_t r, logic [1:0] rate);
    logic hi;
    hi = (rate == `RATE_MAX);
    unique case (r)
      radio_cfg_pkg::REG_US: min_count = `MF_US;
      radio_cfg_pkg::REG_AU: min_count = hi ? `MF_AU_HI : `MF_AU_LO;
      radio_cfg_pkg::REG_NZ: min_count = hi ? `MF_NZ_HI : `MF_NZ_LO;
      radio_cfg_pkg::REG_BR: min_count = hi ? `MF_BR_HI : `MF_BR_LO;
      default: min_count = `MF_FR;
    endcase
  endfunction

  function automatic radio_cfg_pkg::param_set_t factory(radio_cfg_pkg::region_t r);
    factory.rate = `RATE_DEFAULT;
    factory.mask = cm_table(r, 1'b0);
    factory.preamble = `PREAMBLE_DEFAULT;
    factory.netid = `NETID_DEFAULT;
  endfunction

  // Mask is locked for these regions
  function automatic logic mask_locked(radio_cfg_pkg::region_t r);
    mask_locked = (r == radio_cfg_pkg::REG_AU) || (r == radio_cfg_pkg::REG_NZ);
  endfunction

  // ==========================================================
  // Command handling
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.rsp_ok = 1'b0;
    d.rsp_err = 1'b0;
    d.dev_reset = 1'b0;
    // Cleared first so that a save in the same cycle wins over the erase
    if (nv_erase) begin
      d.nv_valid = 1'b0;
    end
    unique case (q.fsm)
      radio_cfg_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          d.rsp_valid = 1'b1;
          d.rsp_ok = 1'b1;
          d.rsp_data = '0;
          unique case (radio_cfg_pkg::cmd_t'(cmd_op))
            radio_cfg_pkg::CMD_APPLY: d.act = q.pend;
            radio_cfg_pkg::CMD_SOFT_RESET: begin
              // Ack goes out now; the reset itself waits for the delay
              d.fsm = radio_cfg_pkg::ST_RST_WAIT;
              d.cnt = '0;
              d.ready = 1'b0;
            end
            radio_cfg_pkg::CMD_RESTORE: begin
              d.pend = factory(q.region);
              d.act = factory(q.region);
            end
            radio_cfg_pkg::CMD_SAVE: begin
              // No ack until storage is written; commands stall meanwhile
              d.rsp_valid = 1'b0;
              d.rsp_ok = 1'b0;
              d.nv = q.pend;
              d.nv_valid = 1'b1;
              d.fsm = radio_cfg_pkg::ST_SAVE;
              d.cnt = '0;
              d.ready = 1'b0;
            end
            radio_cfg_pkg::CMD_WRITE: begin
              d.rsp_ok = 1'b0;
              d.rsp_err = 1'b1;
              unique case (radio_cfg_pkg::param_id_t'(cmd_param))
                radio_cfg_pkg::PAR_RATE: if (cmd_wdata <= 64'(`RATE_MAX)) begin
                  d.pend.rate = cmd_wdata[1:0];
                  d.rsp_err = 1'b0;
                end
                radio_cfg_pkg::PAR_MASK: if (!mask_locked(q.region)) begin
                  d.pend.mask = cmd_wdata[`CHMASK_W-1:0];
                  d.rsp_err = 1'b0;
                end
                radio_cfg_pkg::PAR_PREAMBLE: if (cmd_wdata <= 64'(`PREAMBLE_MAX)) begin
                  d.pend.preamble = cmd_wdata[3:0];
                  d.rsp_err = 1'b0;
                end
                radio_cfg_pkg::PAR_NETID: if (cmd_wdata <= 64'(`NETID_MAX)) begin
                  d.pend.netid = cmd_wdata[14:0];
                  d.rsp_err = 1'b0;
                end
                default: d.rsp_err = 1'b1;
              endcase
              d.rsp_ok = !d.rsp_err;
            end
            radio_cfg_pkg::CMD_READ: begin
              unique case (radio_cfg_pkg::param_id_t'(cmd_param))
                radio_cfg_pkg::PAR_RATE: d.rsp_data = 64'(q.act.rate);
                radio_cfg_pkg::PAR_MASK: d.rsp_data = 64'(q.op_mask);
                radio_cfg_pkg::PAR_PREAMBLE: d.rsp_data = 64'(q.act.preamble);
                radio_cfg_pkg::PAR_NETID: d.rsp_data = 64'(q.act.netid);
                radio_cfg_pkg::PAR_AVAIL: d.rsp_data = 64'(q.af);
                radio_cfg_pkg::PAR_MINCH: d.rsp_data = 64'(q.minch);
                default: begin
                  d.rsp_ok = 1'b0;
                  d.rsp_err = 1'b1;
                end
              endcase
            end
            default: begin
              d.rsp_ok = 1'b0;
              d.rsp_err = 1'b1;
            end
          endcase
        end
      end
      radio_cfg_pkg::ST_SAVE: begin
        d.cnt = q.cnt + 24'h00_0001;
        if (q.cnt == 24'(NV_WRITE_CYC - 1)) begin
          d.fsm = radio_cfg_pkg::ST_IDLE;
          d.ready = 1'b1;
          d.rsp_valid = 1'b1;
          d.rsp_ok = 1'b1;
          d.rsp_data = '0;
        end
      end
      radio_cfg_pkg::ST_RST_WAIT: begin
        d.cnt = q.cnt + 24'h00_0001;
        if (q.cnt == 24'(RESET_DELAY_CYC - 1)) begin
          d.dev_reset = 1'b1;
        end
      end
    endcase
    if (cmd_mode_enter) begin
      d.in_cmd = 1'b1;
    end else if (cmd_mode_exit && q.in_cmd) begin
      d.in_cmd = 1'b0;
      d.act = d.pend;
    end
    // Full reset, from the pin or from the delayed soft reset
    if (srst || d.dev_reset) begin
      if (srst) begin
        d.region = radio_cfg_pkg::region_t'(region_sel);
      end
      d.act = (q.nv_valid && !nv_erase) ? q.nv : factory(d.region);
      d.pend = d.act;
      d.fsm = radio_cfg_pkg::ST_IDLE;
      d.cnt = '0;
      d.in_cmd = 1'b0;
      d.ready = 1'b1;
      d.rsp_valid = 1'b0;
      d.rsp_ok = 1'b0;
      d.rsp_err = 1'b0;
      d.rsp_data = '0;
      d.dev_reset = !srst;
    end
    // Operating channel view, bit 0 is the lowest channel
    d.af = af_bits(d.region, d.act.rate);
    d.op_mask = (d.act.rate == `RATE_MAX) ? cm_table(d.region, 1'b1) : d.act.mask;
    d.active = d.op_mask & d.af;
    d.minch = min_count(d.region, d.act.rate);
    if (d.act.rate != `RATE_MAX) begin
      d.spacing = `SPACING_LO_KHZ;
    end else if (d.region == radio_cfg_pkg::REG_BR) begin
      d.spacing = `SPACING_BR_HI_KHZ;
    end else begin
      d.spacing = `SPACING_HI_KHZ;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign in_cmd_mode_r = q.in_cmd;
  assign cmd_ready_r = q.ready;
  assign rsp_valid_r = q.rsp_valid;
  assign rsp_ok_r = q.rsp_ok;
  assign rsp_err_r = q.rsp_err;
  assign rsp_data_r = q.rsp_data;
  assign dev_reset_r = q.dev_reset;
  assign rf_rate_select_r = q.act.rate;
  assign available_freq_bits_r = q.af;
  assign channel_enable_mask_r = q.op_mask;
  assign active_channels_r = q.active;
  assign min_channel_count_r = q.minch;
  assign chan_spacing_khz_r = q.spacing;

  rx_ident_filter u_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .rx_hdr_valid(rx_hdr_valid),
    .rx_preamble_id(rx_preamble_id),
    .rx_net_id(rx_net_id),
    .own_preamble(q.act.preamble),
    .own_netid(q.act.netid),
    .rx_accept_r(rx_accept_r),
    .rx_drop_preamble_r(rx_drop_preamble_r),
    .rx_drop_net_r(rx_drop_net_r)
  );

  // ==========================================================
  // Checks
  wire logic take = cmd_valid && cmd_ready_r;

  property p_rst_ack;
    @(posedge sys_clk) disable iff (srst)
    take && cmd_op == 3'h1 |=> rsp_valid_r && rsp_ok_r ##1 !cmd_ready_r;
  endproperty
  a_rst_ack: assert property (p_rst_ack)
    else $error("soft reset not acknowledged at once");

  property p_reset_leaves_cmd;
    @(posedge sys_clk) disable iff (srst)
    dev_reset_r |-> !in_cmd_mode_r && cmd_ready_r && $past(!cmd_ready_r);
  endproperty
  a_reset_leaves_cmd: assert property (p_reset_leaves_cmd)
    else $error("device reset left command mode active");

  property p_apply;
    @(posedge sys_clk) disable iff (srst)
    take && cmd_op == 3'h0 |=> rf_rate_select_r == $past(q.pend.rate);
  endproperty
  a_apply: assert property (p_apply)
    else $error("apply did not take effect");

  property p_save_ack;
    @(posedge sys_clk) disable iff (srst)
    take && cmd_op == 3'h3 |=> !rsp_valid_r ##[1:NVW] rsp_valid_r && rsp_ok_r;
  endproperty
  a_save_ack: assert property (p_save_ack)
    else $error("save not acknowledged in time");

  property p_locked_mask;
    @(posedge sys_clk) disable iff (srst)
    take && cmd_op == 3'h4 && cmd_param == 3'h1 && mask_locked(q.region)
      |=> rsp_err_r && q.pend.mask == $past(q.pend.mask);
  endproperty
  a_locked_mask: assert property (p_locked_mask)
    else $error("mask write accepted in locked region");

  property p_ro_write;
    @(posedge sys_clk) disable iff (srst)
    take && cmd_op == 3'h4 && (cmd_param == 3'h4 || cmd_param == 3'h5)
      |=> rsp_valid_r && rsp_err_r && !rsp_ok_r;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write not refused");

  property p_active_subset;
    @(posedge sys_clk) disable iff (srst)
    (active_channels_r & ~available_freq_bits_r) == '0
      && (active_channels_r & ~channel_enable_mask_r) == '0;
  endproperty
  a_active_subset: assert property (p_active_subset)
    else $error("active channel outside mask or available set");

  property p_fixed_mask;
    @(posedge sys_clk) disable iff (srst)
    rf_rate_select_r == 2'h2 |-> channel_enable_mask_r == cm_table(q.region, 1'b1);
  endproperty
  a_fixed_mask: assert property (p_fixed_mask)
    else $error("rate 2 not using fixed mask");

  property p_ranges;
    @(posedge sys_clk) disable iff (srst)
    rf_rate_select_r <= 2'h2 && q.act.preamble <= 4'h9 && q.pend.preamble <= 4'h9;
  endproperty
  a_ranges: assert property (p_ranges)
    else $error("rate or preamble id out of range");

  property p_spacing;
    @(posedge sys_clk) disable iff (srst)
    rf_rate_select_r != 2'h2 |-> chan_spacing_khz_r == 10'h0fa;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("low-rate spacing wrong");

endmodule

// [hw/radio_cfg_params.svh]
// Constants for the radio channel configuration command block:
// timing figures, field limits, channel tables and factory values.
// Included by the package and by every design file that needs them.
`ifndef RADIO_CFG_PARAMS_SVH
`define RADIO_CFG_PARAMS_SVH

// ==========================================================
// Clock and timing
`define SYS_CLK_KHZ 100_000
`define SOFT_RST_DELAY_MS 100
`define NV_WRITE_CYC 16

// ==========================================================
// Field widths and limits
`define CHMASK_W 64
`define RATE_MAX 2'h2
`define PREAMBLE_MAX 4'h9
`define NETID_MAX 15'h7fff

// ==========================================================
// Factory values
`define RATE_DEFAULT 2'h2
`define PREAMBLE_DEFAULT 4'h0
`define NETID_DEFAULT 15'h7fff

// ==========================================================
// Available channels per region and rate (bit 0 = lowest frequency)
`define AF_US_LO 64'hffff_ffff_ffff_ffff
`define AF_US_HI 64'h0003_ffff_ffff_ffff
`define AF_AU_LO 64'h0001_ffff_ffff_ffff
`define AF_AU_HI 64'h0000_0000_00ff_ffff
`define AF_NZ_LO 64'h0000_01ff_ffff_ffff
`define AF_NZ_HI 64'h0000_0000_0000_07ff
`define AF_BR_LO 64'hffff_ffff_ffff_ffff
`define AF_BR_HI 64'h0000_0007_ffff_ffff
`define AF_FR_LO 64'h0000_0000_007f_ffff
`define AF_FR_HI 64'h0000_0000_0000_0fff

// ==========================================================
// Channel masks: default at low rates, fixed at rate 2
`define CM_US_LO 64'h5555_5555_5555_5555
`define CM_US_HI 64'h0003_ffff_ffff_ffff
`define CM_AU_LO 64'h0000_01ff_ffff_ffff
`define CM_AU_HI 64'h0000_0000_00ff_ffff
`define CM_NZ_LO 64'h0000_01ff_ffff_ffff
`define CM_NZ_HI 64'h0000_0000_0000_07ff
`define CM_BR_LO 64'hffff_ffff_fff8_0000
`define CM_BR_HI 64'h0000_0007_ffff_ffff
`define CM_FR_LO 64'h0000_0000_007f_ffff
`define CM_FR_HI 64'h0000_0000_0000_0fff

// ==========================================================
// Minimum hopping channel counts
`define MF_US 8'h32
`define MF_AU_LO 8'h31
`define MF_AU_HI 8'h18
`define MF_NZ_LO 8'h29
`define MF_NZ_HI 8'h0b
`define MF_BR_LO 8'h32
`define MF_BR_HI 8'h23
`define MF_FR 8'h0c

// ==========================================================
// Channel spacing in kHz
`define SPACING_LO_KHZ 10'h0fa
`define SPACING_HI_KHZ 10'h1f4
`define SPACING_BR_HI_KHZ 10'h1c2

`endif

// [hw/radio_cfg_pkg.sv]
// Types shared by the radio channel configuration block and its
// receive identifier filter. Constants live in the params header.
`include "radio_cfg_params.svh"

package radio_cfg_pkg;

  typedef enum logic [2:0] {REG_US, REG_AU, REG_NZ, REG_BR, REG_FR} region_t;

  typedef enum logic [2:0] {
    CMD_APPLY, CMD_SOFT_RESET, CMD_RESTORE, CMD_SAVE, CMD_WRITE, CMD_READ
  } cmd_t;

  typedef enum logic [2:0] {
    PAR_RATE, PAR_MASK, PAR_PREAMBLE, PAR_NETID, PAR_AVAIL, PAR_MINCH
  } param_id_t;

  typedef enum {ST_IDLE, ST_SAVE, ST_RST_WAIT} fsm_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [`CHMASK_W-1:0] mask;
    logic [3:0] preamble;
    logic [14:0] netid;
  } param_set_t;

  typedef struct packed {
    logic accept;
    logic drop_preamble;
    logic drop_net;
  } filt_state_t;

endpackage

// [hw/rx_ident_filter.sv]
// Receive identifier filter: checks each received header against the
// active preamble identifier first, then against the network identifier.
// Header fields arrive from the RF datapath on sys_clk.
`timescale 1ns/1ps
`include "radio_cfg_params.svh"

module rx_ident_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Received header
  input wire logic rx_hdr_valid,
  input wire logic [3:0] rx_preamble_id,
  input wire logic [14:0] rx_net_id,
  // Own identifiers
  input wire logic [3:0] own_preamble,
  input wire logic [14:0] own_netid,
  // Verdict pulses
  output logic rx_accept_r,
  output logic rx_drop_preamble_r,
  output logic rx_drop_net_r
);

  radio_cfg_pkg::filt_state_t q, d;

  // ==========================================================
  // Verdict
  always_comb begin
    d = '0;
    if (!srst && rx_hdr_valid) begin
      // Preamble id is in the preamble, so it is known before the MAC header
      if (rx_preamble_id != own_preamble) begin
        d.drop_preamble = 1'b1;
      end else if (rx_net_id != own_netid) begin
        d.drop_net = 1'b1;
      end else begin
        d.accept = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign rx_accept_r = q.accept;
  assign rx_drop_preamble_r = q.drop_preamble;
  assign rx_drop_net_r = q.drop_net;

  // ==========================================================
  // Checks
  property p_net_after_preamble;
    @(posedge sys_clk) disable iff (srst)
    rx_drop_net_r |-> $past(rx_preamble_id) == $past(own_preamble);
  endproperty
  a_net_after_preamble: assert property (p_net_after_preamble)
    else $error("network id rejected although preamble id mismatched");

  property p_accept_match;
    @(posedge sys_clk) disable iff (srst)
    rx_hdr_valid && rx_preamble_id == own_preamble && rx_net_id == own_netid
      |=> rx_accept_r && !rx_drop_net_r && !rx_drop_preamble_r;
  endproperty
  a_accept_match: assert property (p_accept_match)
    else $error("matching header was not accepted");

endmodule

// [bench/host_model.sv]
// Host model: issues one configuration command at a time and waits for its answer.
// Assumes the block's command handshake on sys_clk.
`timescale 1ns/1ps

module host_model (
  // Clock
  input wire logic sys_clk,
  // Command request
  output logic cmd_valid,
  output logic [2:0] cmd_op,
  output logic [2:0] cmd_param,
  output logic [63:0] cmd_wdata,
  input wire logic cmd_ready_r,
  // Response
  input wire logic rsp_valid_r,
  input wire logic rsp_ok_r,
  input wire logic [63:0] rsp_data_r
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_param = 3'h0;
    cmd_wdata = 64'h0000_0000_0000_0000;
  end

  // ==========================================================
  // One request in flight; nothing more is sent before the answer
  task automatic issue(input logic [2:0] op, input logic [2:0] par, input logic [63:0] wd,
                       output logic ok, output logic [63:0] rd, output logic hung);
    int n;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_param = par;
    cmd_wdata = wd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready_r !== 1'b1 && n < 600);
    #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~wd;
    for (n = 0; n < 600 && rsp_valid_r !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    hung = (rsp_valid_r !== 1'b1);
    ok = rsp_ok_r;
    rd = rsp_data_r;
  endtask
endmodule

// [bench/radio_channel_config_tb_top.sv]
// Testbench for the radio channel configuration block.
// Assumes the host model file; short reset and storage delays.
`timescale 1ns/1ps
`include "radio_cfg_params.svh"

module radio_channel_config_tb_top;
  localparam int unsigned RST_CYC = 20;
  logic sys_clk, srst, nv_erase, cmd_mode_enter, cmd_mode_exit, rx_hdr_valid;
  logic in_cmd_mode_r, cmd_valid, cmd_ready_r, rsp_valid_r, rsp_ok_r, rsp_err_r, dev_reset_r;
  logic rx_accept_r, rx_drop_preamble_r, rx_drop_net_r, ok, hung;
  logic [2:0] region_sel, cmd_op, cmd_param;
  logic [3:0] rx_preamble_id;
  logic [14:0] rx_net_id;
  logic [1:0] rf_rate_select_r;
  logic [7:0] min_channel_count_r;
  logic [9:0] chan_spacing_khz_r;
  logic [63:0] cmd_wdata, rsp_data_r, rd, available_freq_bits_r, channel_enable_mask_r;
  logic [63:0] active_channels_r;
  int mismatches, checks, n;

  radio_channel_config #(.RESET_DELAY_CYC(RST_CYC), .NV_WRITE_CYC(4)) radio_channel_config_i (
    .sys_clk(sys_clk), .srst(srst), .nv_erase(nv_erase), .region_sel(region_sel),
    .cmd_mode_enter(cmd_mode_enter), .cmd_mode_exit(cmd_mode_exit),
    .in_cmd_mode_r(in_cmd_mode_r), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_param(cmd_param), .cmd_wdata(cmd_wdata), .cmd_ready_r(cmd_ready_r),
    .rsp_valid_r(rsp_valid_r), .rsp_ok_r(rsp_ok_r), .rsp_err_r(rsp_err_r),
    .rsp_data_r(rsp_data_r), .dev_reset_r(dev_reset_r), .rf_rate_select_r(rf_rate_select_r),
    .available_freq_bits_r(available_freq_bits_r), .channel_enable_mask_r(channel_enable_mask_r),
    .active_channels_r(active_channels_r), .min_channel_count_r(min_channel_count_r),
    .chan_spacing_khz_r(chan_spacing_khz_r), .rx_hdr_valid(rx_hdr_valid),
    .rx_preamble_id(rx_preamble_id), .rx_net_id(rx_net_id), .rx_accept_r(rx_accept_r),
    .rx_drop_preamble_r(rx_drop_preamble_r), .rx_drop_net_r(rx_drop_net_r));

  host_model host_model_i (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_param(cmd_param),
    .cmd_wdata(cmd_wdata), .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r),
    .rsp_ok_r(rsp_ok_r), .rsp_data_r(rsp_data_r));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Access tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [2:0] op, input logic [2:0] par, input logic [63:0] wd,
                     input logic exp_ok);
    host_model_i.issue(op, par, wd, ok, rd, hung);
    if (hung) begin
      mismatches++;
      test_done();
    end
    chk("response ok", 64'(ok), 64'(exp_ok));
    chk("response err", 64'(rsp_err_r), 64'(!exp_ok));
  endtask

  task automatic rd_chk(input logic [2:0] par, input logic [63:0] exp);
    cmd(3'h5, par, 64'h0000_0000_0000_0000, 1'b1);
    chk("read data", rd, exp);
  endtask

  task automatic pulse(input logic enter);
    @(posedge sys_clk);
    #1;
    cmd_mode_enter = enter;
    cmd_mode_exit = ~enter;
    @(posedge sys_clk);
    #1;
    cmd_mode_enter = 1'b0;
    cmd_mode_exit = 1'b0;
    chk("command mode", 64'(in_cmd_mode_r), 64'(enter));
  endtask

  task automatic rx(input logic [3:0] pre, input logic [14:0] net, input logic [2:0] exp);
    @(posedge sys_clk);
    #1;
    rx_hdr_valid = 1'b1;
    rx_preamble_id = pre;
    rx_net_id = net;
    @(posedge sys_clk);
    #1;
    rx_hdr_valid = 1'b0;
    chk("verdict", 64'({rx_accept_r, rx_drop_preamble_r, rx_drop_net_r}), 64'(exp));
  endtask

  task automatic do_reset(input logic [2:0] reg_code, input logic erase);
    srst = 1'b1;
    nv_erase = erase;
    region_sel = reg_code;
    repeat (8) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    nv_erase = 1'b0;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    mismatches = 0;
    checks = 0;
    {cmd_mode_enter, cmd_mode_exit, rx_hdr_valid, rx_preamble_id, rx_net_id} = '0;
    do_reset(3'h0, 1'b1);
    chk("rate", 64'(rf_rate_select_r), 64'h0000_0000_0000_0002);
    chk("avail", available_freq_bits_r, `AF_US_HI);
    chk("spacing", 64'(chan_spacing_khz_r), 64'(`SPACING_HI_KHZ));
    rd_chk(3'h1, `CM_US_HI);
    rd_chk(3'h5, 64'(`MF_US));
    rd_chk(3'h3, 64'h0000_0000_0000_7fff);
    rd_chk(3'h2, 64'h0000_0000_0000_0000);
    $display("defaults done");
    cmd(3'h4, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    chk("pending rate", 64'(rf_rate_select_r), 64'h0000_0000_0000_0002);
    cmd(3'h0, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    chk("rate", 64'(rf_rate_select_r), 64'h0000_0000_0000_0000);
    chk("mask", channel_enable_mask_r, `CM_US_LO);
    chk("spacing", 64'(chan_spacing_khz_r), 64'(`SPACING_LO_KHZ));
    cmd(3'h4, 3'h1, 64'h0003_ffff_ffff_ffff, 1'b1);
    cmd(3'h0, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    rd_chk(3'h1, 64'h0003_ffff_ffff_ffff);
    chk("active", active_channels_r, 64'h0003_ffff_ffff_ffff & `AF_US_LO);
    cmd(3'h4, 3'h4, 64'h0000_0000_0000_0001, 1'b0);
    cmd(3'h4, 3'h5, 64'h0000_0000_0000_0001, 1'b0);
    cmd(3'h4, 3'h0, 64'h0000_0000_0000_0003, 1'b0);
    cmd(3'h4, 3'h2, 64'h0000_0000_0000_000a, 1'b0);
    cmd(3'h4, 3'h3, 64'h0000_0000_0000_8000, 1'b0);
    rd_chk(3'h2, 64'h0000_0000_0000_0000);
    $display("writes done");
    pulse(1'b1);
    cmd(3'h4, 3'h2, 64'h0000_0000_0000_0005, 1'b1);
    rd_chk(3'h2, 64'h0000_0000_0000_0000);
    pulse(1'b0);
    rd_chk(3'h2, 64'h0000_0000_0000_0005);
    rx(4'h5, 15'h7fff, 3'b100);
    rx(4'h4, 15'h7fff, 3'b010);
    rx(4'h4, 15'h0000, 3'b010);
    rx(4'h5, 15'h0000, 3'b001);
    $display("filter done");
    cmd(3'h3, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    pulse(1'b1);
    cmd(3'h1, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    for (n = 0; n < RST_CYC + 8 && dev_reset_r !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("reset delay", 64'(n), 64'(RST_CYC));
    if (n == RST_CYC + 8) begin
      test_done();
    end
    chk("command mode", 64'(in_cmd_mode_r), 64'h0000_0000_0000_0000);
    rd_chk(3'h0, 64'h0000_0000_0000_0000);
    rd_chk(3'h2, 64'h0000_0000_0000_0005);
    cmd(3'h2, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    rd_chk(3'h0, 64'h0000_0000_0000_0002);
    rd_chk(3'h2, 64'h0000_0000_0000_0000);
    $display("special commands done");
    do_reset(3'h1, 1'b1);
    cmd(3'h4, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    cmd(3'h0, 3'h0, 64'h0000_0000_0000_0000, 1'b1);
    cmd(3'h4, 3'h1, 64'h0000_0000_0000_00ff, 1'b0);
    rd_chk(3'h1, `CM_AU_LO);
    chk("min count", 64'(min_channel_count_r), 64'(`MF_AU_LO));
    $display("region done");
    test_done();
  end
endmodule
